// *** pkg/urx_map.svh ***
// Register map, field positions, reset values and timing counts of the receiver
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

// Register indices; byte address is four times the index
`define URX_IDX_RX_STATUS_CTRL 6'h13
`define URX_IDX_TX_STATUS_CTRL 6'h15
`define URX_IDX_BAUD_DIVISOR 6'h17
`define URX_IDX_RX_DATA 6'h10
`define URX_IDX_INT_FLAGS 6'h11
`define URX_IDX_INT_ENABLES 6'h12

// rx_status_ctrl_reg fields
`define URX_RS_SERIAL_PORT_EN 7
`define URX_RS_NINE_BIT_SEL 6
`define URX_RS_SINGLE_RX_EN 5
`define URX_RS_CONT_RX_EN 4
`define URX_RS_FRAMING_ERR 2
`define URX_RS_OVERRUN_ERR 1
`define URX_RS_NINTH_BIT 0

// tx_status_ctrl_reg fields
`define URX_TS_CLK_SOURCE 7
`define URX_TS_SYNC_SEL 4
`define URX_TS_SHIFT_EMPTY 1
`define URX_TS_WRITE_MASK 8'hF1

// Flag and enable fields
`define URX_IF_RX_FULL 0
`define URX_IE_RX_INT 0

// Reset values
`define URX_RST_RX_STATUS_CTRL 8'h00
`define URX_RST_TX_STATUS_CTRL 8'h00
`define URX_RST_BAUD_DIVISOR 8'h00
`define URX_RST_INT_ENABLES 1'b0

// Timing counts
`define URX_PRESCALE_LAST 2'h3
`define URX_FIRST_SAMPLE 4'h6
`define URX_SECOND_SAMPLE 4'h7
`define URX_DECIDE_SAMPLE 4'h8
`define URX_DATA_BITS 4'h8
`define URX_DATA_BITS_NINE 4'h9

`endif

// *** pkg/urx_pkg.sv ***
// Types shared by the receiver design
package urx_pkg;

    typedef enum logic [1:0] {
        URX_IDLE = 2'b00,
        URX_START = 2'b01,
        URX_DATA = 2'b10,
        URX_STOP = 2'b11
    } urx_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] rx_ctrl;
        logic overrun_error;
        logic [7:0] tx_ctrl;
        logic [7:0] baud_divisor_reg;
        logic rx_int_enable;
        logic [1:0] prescale;
        logic [7:0] baud_gen;
        urx_state_t state;
        logic [3:0] phase;
        logic [1:0] samples;
        logic [3:0] bit_count;
        logic [8:0] rx_shift_reg;
        logic framing_error;
    } urx_regs_t;

endpackage : urx_pkg

// *** rtl/urx_top.sv ***
// Asynchronous serial receiver with baud generator, receive FIFO and Wishbone registers
//
// What this block does
// - Free-running 8-bit baud timer, period set by baud divisor register.
// - Async rate Fosc/(64(X+1)), sync rate Fosc/(4(X+1)), X 0..255.
// - Divisor rate applies in async and sync master, not sync slave.
// - Writing the divisor register clears the baud timer immediately.
// - Recovery runs at sixteen times baud; shift register at bit rate.
// - In async mode reception starts only with continuous receive enable set.
// - After stop bit, push word to FIFO if room; raise receive-full flag.
// - Receive-full gives interrupt request only while receive interrupt enable set.
// - Receive-full is read-only, cleared by hardware when FIFO empties.
// - Receive data is a two-entry FIFO; third byte may keep shifting.
// - FIFO full at further stop bit sets overrun; word is discarded.
// - Overrun never self-clears; cleared by resetting receiver via enable bit.
// - While overrun is set, no word enters the FIFO.
// - Missing stop bit sets the framing error bit.
// - Framing error and ninth bit travel per FIFO entry with the data.
// - Bit level is majority of samples on edges 6, 7 and 8.
//
// Added by the designer: the Wishbone interface to the registers.

`include "urx_map.svh"

module urx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } urx_fifo_state_t;

    urx_fifo_state_t cur;
    urx_fifo_state_t next_cur;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("urx_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("urx_fifo: WIDTH must be at least 1");
    end

    assign o_in_ready = (cur.count != CW'(DEPTH));
    assign o_out_valid = (cur.count != '0);
    assign o_out_data = cur.mem[cur.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.mem[cur.wr_ptr] = i_in_data;
            next_cur.wr_ptr = cur.wr_ptr + PW'(1);
        end
        if (pop) begin
            next_cur.rd_ptr = cur.rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            next_cur.count = cur.count + CW'(1);
        end else if (pop && !push) begin
            next_cur.count = cur.count - CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cur <= '0;
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end
endmodule // urx_fifo

module urx_top #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rx_line_pin,
    output logic o_rx_full_flag,
    output logic o_rx_irq
);
    import urx_pkg::*;

    localparam int ENTRY_W = 10;

    urx_regs_t cur;
    urx_regs_t next_cur;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [ENTRY_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [ENTRY_W-1:0] fifo_out_data;

    logic req;
    logic [5:0] idx;
    logic wr_lane0;
    logic rx_on;
    logic gen_run;
    logic baud_tick;
    logic [3:0] next_phase;
    logic vote;
    logic nine_mode;
    logic [3:0] last_bit;
    logic frame_done;
    logic [7:0] done_data;
    logic done_ninth;
    logic done_framing_error;
    logic [7:0] status_rd;
    logic [7:0] tx_rd;

    // Depth must suit the FIFO's pointer arithmetic
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo_depth
        $error("urx_top: FIFO_DEPTH must be a power of two, at least 2");
    end

    urx_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // Bus request decode
    assign req = i_wb_cyc && i_wb_stb && !cur.ack;
    assign idx = i_wb_adr[7:2];
    assign wr_lane0 = req && i_wb_we && i_wb_sel[0];

    assign nine_mode = cur.rx_ctrl[`URX_RS_NINE_BIT_SEL];
    assign rx_on = cur.rx_ctrl[`URX_RS_SERIAL_PORT_EN] && cur.rx_ctrl[`URX_RS_CONT_RX_EN]
        && !cur.tx_ctrl[`URX_TS_SYNC_SEL];
    assign gen_run = cur.rx_ctrl[`URX_RS_SERIAL_PORT_EN]
        && !(cur.tx_ctrl[`URX_TS_SYNC_SEL] && !cur.tx_ctrl[`URX_TS_CLK_SOURCE]);
    assign baud_tick = gen_run && (cur.prescale == `URX_PRESCALE_LAST)
        && (cur.baud_gen == cur.baud_divisor_reg);

    assign next_phase = cur.phase + 4'h1;
    assign vote = (cur.samples[0] & cur.samples[1]) | (cur.samples[0] & i_rx_line_pin)
        | (cur.samples[1] & i_rx_line_pin);
    assign last_bit = nine_mode ? (`URX_DATA_BITS_NINE - 4'h1) : (`URX_DATA_BITS - 4'h1);

    // ninth bit only in nine-bit mode
    assign done_data = nine_mode ? cur.rx_shift_reg[7:0] : cur.rx_shift_reg[8:1];
    assign done_ninth = nine_mode ? cur.rx_shift_reg[8] : 1'b0;
    assign done_framing_error = !vote;
    assign frame_done = rx_on && baud_tick && (cur.state == URX_STOP)
        && (next_phase == `URX_DECIDE_SAMPLE);

    assign fifo_in_valid = frame_done && !cur.overrun_error;
    assign fifo_in_data = {done_framing_error, done_ninth, done_data};
    // Reading the data register pops the head entry
    assign fifo_out_ready = req && !i_wb_we && (idx == `URX_IDX_RX_DATA);

    always_comb begin
        status_rd = {cur.rx_ctrl[7:4], 1'b0, 3'b000};
        status_rd[`URX_RS_OVERRUN_ERR] = cur.overrun_error;
        status_rd[`URX_RS_FRAMING_ERR] = fifo_out_valid && fifo_out_data[ENTRY_W-1];
        status_rd[`URX_RS_NINTH_BIT] = fifo_out_valid && fifo_out_data[ENTRY_W-2];
        tx_rd = cur.tx_ctrl;
        tx_rd[`URX_TS_SHIFT_EMPTY] = 1'b1;
    end

    always_comb begin
        next_cur = cur;
        next_cur.ack = req;

        // Register reads, answered with ack one cycle later
        if (req && !i_wb_we) begin
            next_cur.rdat = 32'h0000_0000;
            unique case (idx)
                `URX_IDX_RX_STATUS_CTRL: next_cur.rdat[7:0] = status_rd;
                `URX_IDX_TX_STATUS_CTRL: next_cur.rdat[7:0] = tx_rd;
                `URX_IDX_BAUD_DIVISOR: next_cur.rdat[7:0] = cur.baud_divisor_reg;
                `URX_IDX_RX_DATA: next_cur.rdat[7:0] = fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
                `URX_IDX_INT_FLAGS: next_cur.rdat[`URX_IF_RX_FULL] = fifo_out_valid;
                `URX_IDX_INT_ENABLES: next_cur.rdat[`URX_IE_RX_INT] = cur.rx_int_enable;
                default: next_cur.rdat = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (wr_lane0) begin
            unique case (idx)
                `URX_IDX_RX_STATUS_CTRL: next_cur.rx_ctrl = {i_wb_dat[7:4], 4'h0};
                `URX_IDX_TX_STATUS_CTRL: next_cur.tx_ctrl = i_wb_dat[7:0] & `URX_TS_WRITE_MASK;
                `URX_IDX_BAUD_DIVISOR: next_cur.baud_divisor_reg = i_wb_dat[7:0];
                `URX_IDX_INT_ENABLES: next_cur.rx_int_enable = i_wb_dat[`URX_IE_RX_INT];
                default: next_cur.rx_int_enable = cur.rx_int_enable;
            endcase
        end

        if (gen_run) begin
            next_cur.prescale = cur.prescale + 2'h1;
            if (cur.prescale == `URX_PRESCALE_LAST) begin
                next_cur.baud_gen = baud_tick ? 8'h00 : cur.baud_gen + 8'h01;
            end
        end
        if (wr_lane0 && idx == `URX_IDX_BAUD_DIVISOR) begin
            next_cur.prescale = 2'h0;
            next_cur.baud_gen = 8'h00;
        end

        // x16 recovery, one bit per 16 ticks
        if (rx_on && baud_tick) begin
            next_cur.phase = next_phase;
            if (next_phase == `URX_FIRST_SAMPLE) begin
                next_cur.samples[0] = i_rx_line_pin;
            end
            if (next_phase == `URX_SECOND_SAMPLE) begin
                next_cur.samples[1] = i_rx_line_pin;
            end
            unique case (cur.state)
                URX_IDLE: begin
                    next_cur.phase = 4'h0;
                    if (!i_rx_line_pin) begin
                        next_cur.state = URX_START;
                    end
                end
                URX_START: begin
                    if (next_phase == `URX_DECIDE_SAMPLE && vote) begin
                        next_cur.state = URX_IDLE;
                    end else if (next_phase == 4'h0) begin
                        next_cur.state = URX_DATA;
                        next_cur.bit_count = 4'h0;
                    end
                end
                URX_DATA: begin
                    if (next_phase == `URX_DECIDE_SAMPLE) begin
                        next_cur.rx_shift_reg = {vote, cur.rx_shift_reg[8:1]};
                    end else if (next_phase == 4'h0) begin
                        if (cur.bit_count == last_bit) begin
                            next_cur.state = URX_STOP;
                        end else begin
                            next_cur.bit_count = cur.bit_count + 4'h1;
                        end
                    end
                end
                URX_STOP: begin
                    // stop bit low marks framing error
                    if (next_phase == `URX_DECIDE_SAMPLE) begin
                        next_cur.framing_error = !vote;
                        next_cur.state = URX_IDLE;
                    end
                end
            endcase
        end

        if (frame_done && !cur.overrun_error && !fifo_in_ready) begin
            next_cur.overrun_error = 1'b1;
        end

        if (!cur.rx_ctrl[`URX_RS_CONT_RX_EN] || !cur.rx_ctrl[`URX_RS_SERIAL_PORT_EN]) begin
            next_cur.overrun_error = 1'b0;
            next_cur.state = URX_IDLE;
            next_cur.phase = 4'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cur <= '0;
            cur.rx_ctrl <= `URX_RST_RX_STATUS_CTRL;
            cur.tx_ctrl <= `URX_RST_TX_STATUS_CTRL;
            cur.baud_divisor_reg <= `URX_RST_BAUD_DIVISOR;
            cur.rx_int_enable <= `URX_RST_INT_ENABLES;
            cur.state <= URX_IDLE;
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    assign o_wb_ack = cur.ack;
    assign o_wb_dat = cur.rdat;
    assign o_rx_full_flag = fifo_out_valid;
    assign o_rx_irq = fifo_out_valid && cur.rx_int_enable;
endmodule // urx_top

// *** verification/urx_props.sv ***
// Concurrent checks on the receiver's bus and flag ports
module urx_props (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_rx_full_flag,
    input wire logic o_rx_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_take;
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
    endsequence
    sequence s_rd(logic [5:0] idx);
        s_take ##0 (!i_wb_we && i_wb_adr[7:2] == idx) ##1 o_wb_ack;
    endsequence
    AST_ACK_LATENCY: assert property (s_take |=> o_wb_ack)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_HIGH_ZERO: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("read data above the register byte not zero");
    AST_IRQ_NEEDS_FLAG: assert property (o_rx_irq |-> o_rx_full_flag)
        else $error("interrupt request without full flag");
    AST_IRQ_RISE: assert property ($rose(o_rx_irq) |->
        ($rose(o_rx_full_flag) || $past(i_wb_cyc && i_wb_we)))
        else $error("interrupt request rose without cause");
    AST_FLAG_READ: assert property (s_rd(6'h11) |-> o_wb_dat[0] == $past(o_rx_full_flag))
        else $error("flag register disagrees with full flag");
    AST_EMPTY_READ: assert property ((s_take ##0 (!i_wb_we && i_wb_adr[7:2] == 6'h10 && !o_rx_full_flag))
        |=> o_wb_dat == 32'h0)
        else $error("empty receive data read not zero");
    AST_FULL_FALL: assert property ($fell(o_rx_full_flag) |-> $past(i_wb_cyc && i_wb_stb))
        else $error("full flag fell without a bus access");
endmodule // urx_props

bind urx_top urx_props i_props (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_rx_full_flag(o_rx_full_flag), .o_rx_irq(o_rx_irq));

// *** verification/urx_tx_model.sv ***
// Behavioural serial transmitter driving the receive line
module urx_tx_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [8:0] i_data,
    input wire logic i_nine,
    input wire logic i_bad_stop,
    input wire logic [15:0] i_bit_len,
    output logic o_line,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic put(input logic v);
        o_line <= v;
        repeat (i_bit_len) @(posedge i_clk);
    endtask
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_busy <= 1'b1;
                put(1'b0);
                for (int i = 0; i < 9; i++) begin
                    if (i < 8 || i_nine) begin
                        put(i_data[i]);
                    end
                end
                put(!i_bad_stop);
                put(1'b1);
                o_busy <= 1'b0;
            end
        end
    end
endmodule // urx_tx_model

// *** verification/tb.sv ***
// Self-checking bench for the serial receiver
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ack, full, irq, line, busy, go = 1'b0, nine = 1'b0, bad = 1'b0, ce = 1'b1;
    logic [7:0] adr = 8'h00, lfsr = 8'h38, rd;
    logic [31:0] wdat = 32'h0, rdat;
    logic [8:0] tx_data = 9'h000;
    logic [15:0] bit_len = 16'h0040;
    logic [7:0] q [3];
    int fails = 0, total_checks = 0, cycles = 0;
    urx_top #(.FIFO_DEPTH(2)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_rx_line_pin(line), .o_rx_full_flag(full), .o_rx_irq(irq));
    urx_tx_model i_tx (.i_clk(i_clk), .i_go(go), .i_data(tx_data), .i_nine(nine), .i_bad_stop(bad),
        .i_bit_len(bit_len), .o_line(line), .o_busy(busy));
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [7:0] stat(input logic [7:0] c, input logic fe, ov, n9);
        return {c[7:4], 1'b0, fe, ov, n9};
    endfunction
    task automatic final_report();
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge i_clk);
        while (ack !== 1'b1) @(posedge i_clk);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk_rd(input string n, input logic [5:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        `CHK(n, e, rd)
    endtask
    task automatic send(input logic [8:0] d, input logic b);
        @(posedge i_clk);
        tx_data <= d;
        bad <= b;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        while (busy) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
    endtask
    initial forever #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        chk_rd("rx_ctrl", 6'h13, 8'h00);
        chk_rd("tx_ctrl", 6'h15, 8'h02);
        lfsr = next_rand(lfsr);
        wb(1'b1, 6'h17, lfsr);
        chk_rd("divisor", 6'h17, lfsr);
        chk_rd("unmapped", 6'h00, 8'h00);
        wb(1'b1, 6'h17, 8'h00);
        wb(1'b1, 6'h13, 8'h90);
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            q[i] = lfsr;
            send({1'b0, lfsr}, 1'b0);
        end
        `CHK("full", 1'b1, full)
        chk_rd("overrun", 6'h13, stat(8'h90, 1'b0, 1'b1, 1'b0));
        chk_rd("data0", 6'h10, q[0]);
        chk_rd("data1", 6'h10, q[1]);
        `CHK("empty", 1'b0, full)
        chk_rd("empty_data", 6'h10, 8'h00);
        send(9'h0A5, 1'b0);
        `CHK("blocked", 1'b0, full)
        wb(1'b1, 6'h13, 8'h80);
        wb(1'b1, 6'h13, 8'h90);
        chk_rd("ovr_clear", 6'h13, 8'h90);
        wb(1'b1, 6'h13, 8'hD0);
        nine <= 1'b1;
        lfsr = next_rand(lfsr);
        q[0] = lfsr;
        send({1'b0, lfsr}, 1'b1);
        lfsr = next_rand(lfsr);
        send({1'b1, lfsr}, 1'b0);
        chk_rd("framing_error", 6'h13, stat(8'hD0, 1'b1, 1'b0, 1'b0));
        chk_rd("data_fe", 6'h10, q[0]);
        chk_rd("ninth", 6'h13, stat(8'hD0, 1'b0, 1'b0, 1'b1));
        chk_rd("data_n9", 6'h10, lfsr);
        send(9'h15A, 1'b0);
        `CHK("irq_off", 1'b0, irq)
        wb(1'b1, 6'h12, 8'h01);
        @(posedge i_clk);
        `CHK("irq_on", 1'b1, irq)
        wb(1'b1, 6'h12, 8'h00);
        @(posedge i_clk);
        `CHK("irq_mask", 1'b0, irq)
        chk_rd("flags", 6'h11, 8'h01);
        wb(1'b1, 6'h11, 8'h00);
        `CHK("flag_ro", 1'b1, full)
        chk_rd("data_9b", 6'h10, 8'h5A);
        nine <= 1'b0;
        wb(1'b1, 6'h13, 8'h80);
        send(9'h033, 1'b0);
        `CHK("rx_off", 1'b0, full)
        wb(1'b1, 6'h13, 8'h90);
        wb(1'b1, 6'h17, 8'h01);
        bit_len <= 16'h0080;
        lfsr = next_rand(lfsr);
        send({1'b0, lfsr}, 1'b0);
        chk_rd("rate", 6'h10, lfsr);
        // Clock enable low freezes the receiver through a whole frame
        ce <= 1'b0;
        send(9'h03C, 1'b0);
        ce <= 1'b1;
        `CHK("ce_freeze", 1'b0, full)
        lfsr = next_rand(lfsr);
        send({1'b0, lfsr}, 1'b0);
        `CHK("pre_reset", 1'b1, full)
        // Reset in mid-run empties the FIFO and clears registers
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        `CHK("reset_full", 1'b0, full)
        chk_rd("reset_div", 6'h17, 8'h00);
        wb(1'b1, 6'h13, 8'h90);
        wb(1'b1, 6'h15, 8'h10);
        send(9'h0C3, 1'b0);
        `CHK("sync_slave", 1'b0, full)
        final_report();
    end
endmodule // tb
